// *** hw/rcs_clk_div.sv ***
`timescale 1ns/100ps
module rcs_clk_div #(
	parameter int RATIO = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	localparam int W = (RATIO < 2) ? 1 : $clog2(RATIO);

	logic [W-1:0] cnt;
	wire wrap = (cnt == W'(RATIO - 1));

	generate
		if (RATIO < 2)
		begin : g_bad
			$error("rcs_clk_div ratio below two");
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= '0;
			tick <= 1'b0;
		end
		else
		begin
			cnt <= wrap ? '0 : cnt + W'(1);
			tick <= wrap;
		end
	end

endmodule : rcs_clk_div

// *** hw/rcs_defines.svh ***
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

// Clock, reset and interrupt pulse timing
`define RCS_CLK_PERIOD_NS 10
`define RCS_RST_MIN_NS 250000
`define RCS_P_GEN_MIN 2
`define RCS_P_GEN_DRIVE 4
`define RCS_P_GEN_MAX 8
`define RCS_E_FLOAT_TICKS 3
`define RCS_E_DRIVE_TICKS 17
`define RCS_EXT_IRQ_MIN_P 8
`define RCS_NMI_MIN_P 4

// Divided clock ratios
`define RCS_DIV_R0 2
`define RCS_DIV_R1 4
`define RCS_DIV_R2 6
`define RCS_DIV_R3 8
`define RCS_DIV_IDX_4 1
`define RCS_DIV_IDX_6 2

// Clock-mode strap codes and multipliers
`define RCS_MODE_BYPASS 2'h0
`define RCS_MODE_X6 2'h1
`define RCS_MODE_X12 2'h2
`define RCS_MULT_X1 4'h1
`define RCS_MULT_X6 4'h6
`define RCS_MULT_X12 4'hC

// Memory clock source select
`define RCS_ESRC_PIN 2'h0
`define RCS_ESRC_DIV4 2'h1
`define RCS_ESRC_DIV6 2'h2

// Register offsets
`define RCS_REG_CTRL 8'h00
`define RCS_REG_STATUS 8'h04
`define RCS_REG_STRAP 8'h08
`define RCS_REG_IRQ 8'h0C

// Field positions
`define RCS_CTRL_ESRC_LSB 0
`define RCS_CTRL_ESRC_MSB 1
`define RCS_ST_HELD_BIT 0
`define RCS_ST_REL_BIT 1
`define RCS_ST_RUN_BIT 2
`define RCS_ST_MODE_RSV_BIT 3
`define RCS_ST_SHORT_BIT 4
`define RCS_STRAP_LSB 0
`define RCS_STRAP_MSB 5
`define RCS_STRAP_MODE_LSB 8
`define RCS_STRAP_MODE_MSB 9
`define RCS_STRAP_MULT_LSB 12
`define RCS_STRAP_MULT_MSB 15
`define RCS_IRQ_EXT_BIT 0
`define RCS_IRQ_NMI_BIT 1

`endif

// *** hw/rcs_pkg.sv ***
package rcs_pkg;

	typedef enum logic [1:0] {ST_HELD, ST_REL, ST_RUN} rcs_state_t;

	typedef struct packed {
		logic [3:0] addr_cfg;
		logic endian;
		logic host_bit5;
	} rcs_straps_t;

	typedef struct packed {
		logic gen_oe_n;
		logic mem_oe_n;
		logic mem_clk_oe_n;
	} rcs_pads_t;

endpackage : rcs_pkg

// *** hw/rcs_top.sv ***
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "rcs_defines.svh"

// Notes on behaviour
// - Straps are captured at the reset rising edge while still held stable.
// - Straps are address bits 22:19, endian select and host data bit five.
// - General pins float during reset, driven again 2 to 8 cycles after release.
// - Memory pins float 2E..3P+4E after assertion, drive 16E..8P+20E after release.
// - Memory input clock resynchronised after assertion and after release.
// - Memory output clock floats no sooner than 2E, driven within 8P+20E.
// - Hold acknowledge invalid no sooner than 2E, valid within 8P+20E.
// - Bus request and low hold acknowledge follow the same invalid/valid timing.
// - CPU clock multiplier chosen from the two clock-mode straps.
// - Divided enables of two, four, six and eight from the CPU clock.
// - Mode 00 bypass, 01 times six, 10 times twelve, 11 reserved.
module rcs_top
	import rcs_pkg::*;
#(
	parameter int RST_MIN_CYC =
		(`RCS_RST_MIN_NS + `RCS_CLK_PERIOD_NS - 1) / `RCS_CLK_PERIOD_NS,
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dev_reset_n,
	input wire logic [3:0] ext_mem_address,
	input wire logic endian_select_pin,
	input wire logic host_data_bit_five,
	input wire logic [1:0] pll_mode_select,
	input wire logic ext_mem_clock_in,
	input wire logic hold_req,
	input wire logic mem_req,
	input wire logic external_irq_pin,
	input wire logic nmi_pin,
	output rcs_pads_t pads,
	output logic ext_mem_clock_out_one,
	output logic bus_hold_ack,
	output logic bus_request_out,
	output logic clk_resync,
	output logic core_rst_n,
	output rcs_straps_t straps,
	output logic [3:0] pll_mult,
	output logic pll_bypass,
	output logic [3:0] div_en,
	output logic [1:0] irq_event
);
	localparam int HW = $clog2(RST_MIN_CYC + 1);
	localparam int DIV_R [4] = '{`RCS_DIV_R0, `RCS_DIV_R1, `RCS_DIV_R2, `RCS_DIV_R3};
	localparam int IRQ_W [2] = '{`RCS_EXT_IRQ_MIN_P, `RCS_NMI_MIN_P};

	generate
		if (ADDR_W < 4 || RST_MIN_CYC < 1)
		begin : g_bad
			$error("rcs_top parameters out of range");
		end
	endgenerate

	rcs_state_t state, next_state;
	logic [4:0] e_cnt, next_e_cnt;
	logic [3:0] p_cnt, next_p_cnt;
	logic [HW-1:0] held_cyc;
	logic rst_q, eclk_q, short_flag, mode_rsv;
	logic [1:0] esrc_ctrl, esrc_act;
	logic [1:0] irq_seen;
	logic [1:0] mode_q;
	wire [3:0] div_tick;
	logic [1:0] irq_qual;
	logic [3:0] irq_cnt [2];

	// Reset pin edges; pins are synchronous to pclk
	wire fall_det = rst_q && !dev_reset_n;
	wire rise_det = !rst_q && dev_reset_n;
	wire [1:0] irq_pins = {nmi_pin, external_irq_pin};

	// Memory clock period source: pin edges or CPU/4, CPU/6
	wire pin_edge = ext_mem_clock_in && !eclk_q;
	wire e_tick = (esrc_act == `RCS_ESRC_DIV4) ? div_tick[`RCS_DIV_IDX_4] :
		(esrc_act == `RCS_ESRC_DIV6) ? div_tick[`RCS_DIV_IDX_6] : pin_edge;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_div
			rcs_clk_div #(.RATIO(DIV_R[gi])) u_div (
				.pclk(pclk),
				.presetn(presetn),
				.tick(div_tick[gi])
			);
		end
	endgenerate

	always_comb
	begin
		next_state = state;
		next_e_cnt = e_cnt;
		next_p_cnt = p_cnt;
		unique case (state)
			ST_RUN:
			begin
				if (fall_det)
				begin
					next_state = ST_HELD;
					next_e_cnt = '0;
				end
			end
			ST_HELD:
			begin
				if (rise_det)
				begin
					next_state = ST_REL;
					next_e_cnt = '0;
					next_p_cnt = '0;
				end
				else if (e_tick && e_cnt < 5'(`RCS_E_FLOAT_TICKS))
					next_e_cnt = e_cnt + 5'h1;
			end
			ST_REL:
			begin
				if (fall_det)
				begin
					// Memory group is still floated; restarting the count would drive it
					next_state = ST_HELD;
					next_e_cnt = 5'(`RCS_E_FLOAT_TICKS);
				end
				else
				begin
					if (p_cnt < 4'(`RCS_P_GEN_DRIVE))
						next_p_cnt = p_cnt + 4'h1;
					if (e_tick && e_cnt < 5'(`RCS_E_DRIVE_TICKS))
						next_e_cnt = e_cnt + 5'h1;
					if (next_e_cnt == 5'(`RCS_E_DRIVE_TICKS)
						&& next_p_cnt == 4'(`RCS_P_GEN_DRIVE))
						next_state = ST_RUN;
				end
			end
		endcase
	end

	// General pins float from the first edge after assertion
	wire next_gen_oe_n = (next_state == ST_HELD) ||
		(next_state == ST_REL && next_p_cnt < 4'(`RCS_P_GEN_DRIVE));
	// Third tick guarantees two full E periods whatever the phase
	wire next_mem_oe_n = (next_state == ST_HELD && next_e_cnt >= 5'(`RCS_E_FLOAT_TICKS)) ||
		(next_state == ST_REL && next_e_cnt < 5'(`RCS_E_DRIVE_TICKS));
	wire next_resync = e_tick && ((state == ST_HELD && !rise_det
		&& e_cnt == 5'(`RCS_E_FLOAT_TICKS - 1)) || (state == ST_REL && !fall_det
		&& e_cnt == 5'(`RCS_E_DRIVE_TICKS - 1)));

	wire [3:0] dec_mult = (pll_mode_select == `RCS_MODE_X6) ? `RCS_MULT_X6 :
		(pll_mode_select == `RCS_MODE_X12) ? `RCS_MULT_X12 : `RCS_MULT_X1;
	wire dec_rsv = (pll_mode_select != `RCS_MODE_BYPASS) &&
		(pll_mode_select != `RCS_MODE_X6) && (pll_mode_select != `RCS_MODE_X12);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_HELD;
			// Held since power-up, so the memory group starts floated
			e_cnt <= 5'(`RCS_E_FLOAT_TICKS);
			p_cnt <= '0;
			rst_q <= 1'b0;
			eclk_q <= 1'b0;
			pads <= '{gen_oe_n: 1'b1, mem_oe_n: 1'b1, mem_clk_oe_n: 1'b1};
			clk_resync <= 1'b0;
			core_rst_n <= 1'b0;
			esrc_act <= `RCS_ESRC_PIN;
		end
		else
		begin
			state <= next_state;
			e_cnt <= next_e_cnt;
			p_cnt <= next_p_cnt;
			rst_q <= dev_reset_n;
			eclk_q <= ext_mem_clock_in;
			pads.gen_oe_n <= next_gen_oe_n;
			pads.mem_oe_n <= next_mem_oe_n;
			pads.mem_clk_oe_n <= next_mem_oe_n;
			clk_resync <= next_resync;
			if (next_resync)
				esrc_act <= esrc_ctrl;
			core_rst_n <= (next_state == ST_RUN);
		end
	end

	// Output clock, hold acknowledge and bus request gated by the memory group
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_mem_clock_out_one <= 1'b0;
			bus_hold_ack <= 1'b0;
			bus_request_out <= 1'b0;
			div_en <= '0;
		end
		else
		begin
			ext_mem_clock_out_one <= !next_mem_oe_n && ext_mem_clock_in;
			bus_hold_ack <= !next_mem_oe_n && hold_req;
			bus_request_out <= !next_mem_oe_n && mem_req;
			div_en <= div_tick;
		end
	end

	// Straps sampled at release, inside the pin hold window
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			straps <= '0;
			mode_q <= `RCS_MODE_BYPASS;
			pll_mult <= `RCS_MULT_X1;
			pll_bypass <= 1'b1;
			mode_rsv <= 1'b0;
		end
		else if (state == ST_HELD && rise_det)
		begin
			straps <= '{addr_cfg: ext_mem_address, endian: endian_select_pin,
				host_bit5: host_data_bit_five};
			mode_q <= pll_mode_select;
			pll_mult <= dec_mult;
			pll_bypass <= (dec_mult == `RCS_MULT_X1);
			mode_rsv <= dec_rsv;
		end
	end

	// Reset width check; a short pulse still resets, but software can see it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			held_cyc <= '0;
		else if (state != ST_HELD)
			held_cyc <= '0;
		else if (held_cyc < HW'(RST_MIN_CYC))
			held_cyc <= held_cyc + HW'(1);
	end

	wire short_set = (state == ST_HELD) && rise_det && (held_cyc < HW'(RST_MIN_CYC));

	// Interrupt pulse qualifiers: level accepted after holding its minimum width
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_irq
			wire differ = (irq_pins[gi] != irq_qual[gi]);
			wire take = differ && (irq_cnt[gi] == 4'(IRQ_W[gi] - 1));
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					irq_cnt[gi] <= '0;
					irq_qual[gi] <= 1'b1;
					irq_event[gi] <= 1'b0;
				end
				else
				begin
					irq_cnt[gi] <= (differ && !take) ? irq_cnt[gi] + 4'h1 : 4'h0;
					if (take)
						irq_qual[gi] <= irq_pins[gi];
					irq_event[gi] <= take && irq_pins[gi];
				end
			end
		end
	endgenerate

	// APB slave: decode in setup, answer in the first access cycle
	wire setup = psel && !penable;
	wire wr_acc = psel && penable && pwrite && pready;
	wire [ADDR_W-1:0] a_ctrl = ADDR_W'(`RCS_REG_CTRL);
	wire [ADDR_W-1:0] a_stat = ADDR_W'(`RCS_REG_STATUS);
	wire [ADDR_W-1:0] a_strap = ADDR_W'(`RCS_REG_STRAP);
	wire [ADDR_W-1:0] a_irq = ADDR_W'(`RCS_REG_IRQ);
	wire hit = (paddr == a_ctrl) || (paddr == a_stat) || (paddr == a_strap) || (paddr == a_irq);
	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = '0;
		if (paddr == a_ctrl)
			rd_mux[`RCS_CTRL_ESRC_MSB:`RCS_CTRL_ESRC_LSB] = esrc_ctrl;
		if (paddr == a_stat)
		begin
			rd_mux[`RCS_ST_HELD_BIT] = (state == ST_HELD);
			rd_mux[`RCS_ST_REL_BIT] = (state == ST_REL);
			rd_mux[`RCS_ST_RUN_BIT] = (state == ST_RUN);
			rd_mux[`RCS_ST_MODE_RSV_BIT] = mode_rsv;
			rd_mux[`RCS_ST_SHORT_BIT] = short_flag;
		end
		if (paddr == a_strap)
		begin
			rd_mux[`RCS_STRAP_MSB:`RCS_STRAP_LSB] = straps;
			rd_mux[`RCS_STRAP_MODE_MSB:`RCS_STRAP_MODE_LSB] = mode_q;
			rd_mux[`RCS_STRAP_MULT_MSB:`RCS_STRAP_MULT_LSB] = pll_mult;
		end
		if (paddr == a_irq)
			rd_mux[`RCS_IRQ_NMI_BIT:`RCS_IRQ_EXT_BIT] = irq_seen;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			esrc_ctrl <= `RCS_ESRC_PIN;
			short_flag <= 1'b0;
			irq_seen <= '0;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup && !hit;
			prdata <= (setup && !pwrite) ? rd_mux : prdata;
			if (wr_acc && paddr == a_ctrl && pstrb[0])
				esrc_ctrl <= pwdata[`RCS_CTRL_ESRC_MSB:`RCS_CTRL_ESRC_LSB];
			// Hardware set wins over a write-one clear in the same cycle
			if (short_set)
				short_flag <= 1'b1;
			else if (wr_acc && paddr == a_stat && pstrb[0] && pwdata[`RCS_ST_SHORT_BIT])
				short_flag <= 1'b0;
			for (int i = 0; i < 2; i++)
			begin
				if (irq_event[i])
					irq_seen[i] <= 1'b1;
				else if (wr_acc && paddr == a_irq && pstrb[0] && pwdata[i])
					irq_seen[i] <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_gen_float_now: assert property (fall_det |=> pads.gen_oe_n)
		else $error("general pins not floated after reset assertion");
	a_gen_drive_late: assert property (rise_det && state == ST_HELD |=>
		pads.gen_oe_n ##[1:7] !pads.gen_oe_n || state == ST_HELD)
		else $error("general pins not driven within window");
	a_mem_float_min: assert property ($rose(pads.mem_oe_n) && state == ST_HELD |->
		$past(e_cnt) >= 5'(`RCS_E_FLOAT_TICKS - 1))
		else $error("memory pins floated too early");
	a_mem_drive_min: assert property ($fell(pads.mem_oe_n) |->
		$past(e_cnt) >= 5'(`RCS_E_DRIVE_TICKS - 1))
		else $error("memory pins driven too early");
	a_clk_out_tie: assert property (pads.mem_clk_oe_n |-> !ext_mem_clock_out_one)
		else $error("memory clock toggles while floated");
	a_bus_out_gate: assert property (pads.mem_oe_n |-> !bus_hold_ack && !bus_request_out)
		else $error("bus handshake valid during reset");
	a_resync_pair: assert property ($fell(pads.mem_oe_n) |-> clk_resync)
		else $error("no resync before memory drive");
	a_strap_catch: assert property (rise_det && state == ST_HELD |=>
		straps.addr_cfg == $past(ext_mem_address) && straps.host_bit5 == $past(host_data_bit_five))
		else $error("straps not captured at release");
	a_pll_decode: assert property (rise_det && state == ST_HELD
		&& pll_mode_select == `RCS_MODE_X12 |=> pll_mult == `RCS_MULT_X12 && !pll_bypass)
		else $error("clock mode decode wrong");
	a_irq_ext_width: assert property ($rose(irq_qual[0]) |->
		$past(external_irq_pin, 1) && $past(external_irq_pin, 8))
		else $error("external interrupt accepted too short");
	a_irq_nmi_width: assert property ($rose(irq_qual[1]) |->
		$past(nmi_pin, 1) && $past(nmi_pin, 4))
		else $error("nmi accepted too short");
	a_short_flag: assert property (short_set |=> short_flag)
		else $error("short reset not flagged");

endmodule : rcs_top

// *** testbench/rcs_board_model.sv ***
`timescale 1ns/100ps
module rcs_board_model
(
	input wire logic pclk,
	output logic dev_reset_n,
	output logic [3:0] ext_mem_address,
	output logic endian_select_pin,
	output logic host_data_bit_five,
	output logic [1:0] pll_mode_select,
	output logic ext_mem_clock_in
);
	logic [1:0] ediv = 2'h0;
	logic [5:0] strap_val = 6'h00;
	int hold_cnt = 0;
	// Reset held from power-up, reference clock already running
	initial
	begin
		dev_reset_n = 1'b0;
		pll_mode_select = 2'h0;
		ext_mem_clock_in = 1'b0;
	end
	always @(posedge pclk)
	begin
		ediv <= ediv + 2'h1;
		ext_mem_clock_in <= ediv[1];
		hold_cnt <= dev_reset_n ? hold_cnt + 1 : 0;
	end
	// Straps let go after the hold time so a late capture sees junk
	assign {ext_mem_address, endian_select_pin, host_data_bit_five} =
		(hold_cnt < 4) ? strap_val : ~strap_val;
	task automatic hold_reset(input logic [5:0] s, input logic [1:0] m);
		dev_reset_n <= 1'b0;
		strap_val <= s;
		pll_mode_select <= m;
	endtask : hold_reset
	task automatic release_reset();
		dev_reset_n <= 1'b1;
	endtask : release_reset
endmodule : rcs_board_model

// *** testbench/tb_reset_clock_sequencer.sv ***
`timescale 1ns/100ps
module tb_reset_clock_sequencer
	import rcs_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, hold_req, mem_req, ext_irq, nmi, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, ext_mem_address, pll_mult, div_en;
	logic pready, pslverr, dev_reset_n, endian_select_pin, host_data_bit_five;
	logic ext_mem_clock_in, ext_mem_clock_out_one, bus_hold_ack, bus_request_out;
	logic clk_resync, core_rst_n, pll_bypass;
	logic [1:0] pll_mode_select, irq_event;
	logic [5:0] sv;
	logic [3:0] mult_tab [4] = '{4'h1, 4'h6, 4'hC, 4'h1};
	rcs_pads_t pads;
	rcs_straps_t straps;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	int t_gen, t_mem, t_bus, pulses, ck_hi;
	int cnt [4];

	rcs_top #(.RST_MIN_CYC(20)) rcs_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .dev_reset_n, .ext_mem_address,
		.endian_select_pin, .host_data_bit_five, .pll_mode_select, .ext_mem_clock_in,
		.hold_req, .mem_req, .external_irq_pin(ext_irq), .nmi_pin(nmi), .pads,
		.ext_mem_clock_out_one, .bus_hold_ack, .bus_request_out, .clk_resync, .core_rst_n,
		.straps, .pll_mult, .pll_bypass, .div_en, .irq_event);
	rcs_board_model rcs_board_model_inst (.pclk, .dev_reset_n, .ext_mem_address,
		.endian_select_pin, .host_data_bit_five, .pll_mode_select, .ext_mem_clock_in);

	initial
	begin
		forever #5 pclk = ~pclk;
	end

	task automatic give_verdict();
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	always @(posedge pclk)
	begin
		cycles++;
		// Whole run is near 1250 cycles; a hang is stopped at the 6000-cycle budget, well beyond it
		if (cycles == 6000)
		begin
			mismatches++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rng(input string what, input int lo, input int hi, input int got);
		compares++;
		if (got < lo || got > hi)
		begin
			mismatches++;
			$display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
		end
	endtask : rng

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// First cycle at which each group reaches the wanted state
	task automatic watch(input int len, input logic f);
		t_gen = -1;
		t_mem = -1;
		t_bus = -1;
		pulses = 0;
		ck_hi = 0;
		for (int n = 0; n < len; n++)
		begin
			@(posedge pclk);
			if (t_gen < 0 && pads.gen_oe_n === f) t_gen = n;
			if (t_mem < 0 && pads.mem_oe_n === f) t_mem = n;
			if (t_bus < 0 && bus_request_out === !f) t_bus = n;
			if (clk_resync === 1'b1) pulses++;
			if (ext_mem_clock_out_one === 1'b1) ck_hi++;
		end
	endtask : watch

	task automatic cycle_reset(input logic [5:0] s, input logic [1:0] m, input int low, input int e);
		rcs_board_model_inst.hold_reset(s, m);
		watch(low, 1'b1);
		if (low >= 40)
		begin
			rng("gen float", 0, 1, t_gen);
			rng("mem float", 8, 19, t_mem);
			rng("bus request invalid", 8, low, t_bus);
			chk("resync on hold", 1, pulses);
			chk("clock out floated", 1, pads.mem_clk_oe_n);
			chk("hold ack invalid", 0, bus_hold_ack);
		end
		rcs_board_model_inst.release_reset();
		watch(30 * e, 1'b0);
		rng("gen drive", 2, 8, t_gen);
		rng("mem drive", 16 * e, 8 + 20 * e, t_mem);
		rng("bus request valid", 0, 8 + 20 * e, t_bus);
		chk("resync on release", 1, pulses);
		rng("clock out running", 1, 30 * e, ck_hi);
		chk("hold ack valid", 1, bus_hold_ack);
		chk("straps", s, straps);
		chk("core running", 1, core_rst_n);
	endtask : cycle_reset

	task automatic irq_try(input int w, input int low, input int exp);
		int hits;
		hits = 0;
		if (w == 0) ext_irq <= 1'b0;
		else nmi <= 1'b0;
		repeat (low) @(posedge pclk);
		ext_irq <= 1'b1;
		nmi <= 1'b1;
		repeat (16)
		begin
			@(posedge pclk);
			if (irq_event[w] === 1'b1) hits++;
		end
		chk("irq event", exp, hits);
	endtask : irq_try

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		hold_req = 1'b1;
		mem_req = 1'b1;
		ext_irq = 1'b1;
		nmi = 1'b1;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("pads at reset", 3'h7, pads);
		for (int m = 0; m < 4; m++)
		begin
			sv = 6'h25 ^ 6'(m * 9);
			cycle_reset(sv, 2'(m), (m == 0) ? 30 : 40, 4);
			chk("multiplier", mult_tab[m], pll_mult);
			chk("bypass", m == 0 || m == 3, pll_bypass);
			apb(1'b0, 8'h08, 32'h0);
			chk("strap reg", {16'h0, mult_tab[m], 2'h0, 2'(m), 2'h0, sv}, rd);
		end
		apb(1'b0, 8'h04, 32'h0);
		chk("status run reserved", 32'h0C, rd);
		mem_req <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("bus request follows", 0, bus_request_out);
		hold_req <= 1'b0;
		mem_req <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("hold ack follows", 0, bus_hold_ack);
		hold_req <= 1'b1;
		pstrb <= 4'h0;
		apb(1'b1, 8'h00, 32'h1);
		pstrb <= 4'hF;
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h2, rd);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		cycle_reset(6'h3C, 2'h1, 40, 6);
		cnt = '{default: 0};
		repeat (48)
		begin
			@(posedge pclk);
			for (int i = 0; i < 4; i++) cnt[i] += int'(div_en[i] === 1'b1);
		end
		for (int i = 0; i < 4; i++) chk("divider pulses", 48 / (2 * i + 2), cnt[i]);
		irq_try(0, 8, 1);
		irq_try(0, 7, 0);
		irq_try(1, 4, 1);
		irq_try(1, 3, 0);
		apb(1'b0, 8'h0C, 32'h0);
		chk("irq seen", 32'h3, rd);
		apb(1'b1, 8'h0C, 32'h3);
		apb(1'b0, 8'h0C, 32'h0);
		chk("irq cleared", 32'h0, rd);
		// Too short on purpose: only the status flag is judged
		rcs_board_model_inst.hold_reset(6'h11, 2'h0);
		repeat (10) @(posedge pclk);
		rcs_board_model_inst.release_reset();
		repeat (200) @(posedge pclk);
		apb(1'b0, 8'h04, 32'h0);
		chk("short reset flag", 32'h10, rd & 32'h10);
		apb(1'b1, 8'h04, 32'h10);
		apb(1'b0, 8'h04, 32'h0);
		chk("short flag cleared", 32'h0, rd & 32'h10);
		give_verdict();
	end
endmodule : tb_reset_clock_sequencer
